// [converter_model.sv]
/*
  Behavioural converter behind the readout block: answers temperature and
  current requests. Assumes the bench sets the analog values and the delay.
*/
`default_nettype none
module converter_model (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic slow,
  input wire logic temp_conv_req,
  input wire tcs_pkg::temp_chan_e temp_conv_chan,
  input wire logic [12:0] q_die,
  input wire logic [12:0] q_one,
  input wire logic [12:0] q_two,
  input wire logic [47:0] cs_code,
  input wire logic isense_conv_req,
  output logic temp_conv_ack,
  output logic signed [12:0] temp_conv_quarter,
  output logic isense_conv_ack,
  output logic [47:0] isense_conv_code
);
  timeunit 1ns;
  timeprecision 1ps;
  import tcs_pkg::*;
  int unsigned wt;
  int unsigned wi;

  // Temperature answer; data is scrambled outside the ack so stale reads show
  always_ff @(posedge mclk) begin
    temp_conv_ack <= 1'b0;
    temp_conv_quarter <= ~temp_conv_quarter;
    if (!nrst) begin
      wt <= 0;
      temp_conv_quarter <= 13'h0aaa;
    end else if (temp_conv_req && !temp_conv_ack) begin
      if (wt >= (slow ? 4 : 1)) begin
        wt <= 0;
        temp_conv_ack <= 1'b1;
        temp_conv_quarter <= (temp_conv_chan == CH_DIE) ? q_die :
          ((temp_conv_chan == CH_ONE) ? q_one : q_two);
      end else begin
        wt <= wt + 1;
      end
    end
  end

  // Current answer, straight binary codes, wait one cycle longer than temperature in slow and fast
  always_ff @(posedge mclk) begin
    isense_conv_ack <= 1'b0;
    isense_conv_code <= ~isense_conv_code;
    if (!nrst) begin
      wi <= 0;
      isense_conv_code <= 48'h0000_0000_0000;
    end else if (isense_conv_req && !isense_conv_ack) begin
      if (wi >= (slow ? 5 : 2)) begin
        wi <= 0;
        isense_conv_ack <= 1'b1;
        isense_conv_code <= cs_code;
      end else begin
        wi <= wi + 1;
      end
    end
  end
endmodule
`default_nettype wire

// [isense_filt_if.sv]
/*
  Bundle between the sequencer and the current-sense filter.
  Assumes both ends run on the same clock.
*/
`default_nettype none
interface isense_filt_if #(parameter int unsigned DW = 12, parameter int unsigned N = 4);
  logic sample_valid;
  logic [N*DW-1:0] sample;
  logic [N-1:0] enable;
  logic [2:0] shift;
  logic [N*DW-1:0] filtered;
  logic filtered_valid;
  modport src(output sample_valid, sample, enable, shift, input filtered, filtered_valid);
  modport filt(input sample_valid, sample, enable, shift, output filtered, filtered_valid);
endinterface
`default_nettype wire

// [isense_filter.sv]
/*
  First-order recursive smoothing of the current-sense samples, one state
  word per channel. Assumes the source gives one sample set per step.
*/
`default_nettype none
module isense_filter #(
  parameter int unsigned DW = 12,
  parameter int unsigned N = 4
) (
  input wire logic mclk,
  input wire logic nrst,
  isense_filt_if.filt fif
);
  import tcs_pkg::*;

  logic [DW-1:0] y_reg [N];
  logic valid_reg;

  // y += (x - y) / K, the normalised form of 1/(K-(K-1)z^-1)
  function automatic logic [DW-1:0] filt_step(input logic [DW-1:0] y, input logic [DW-1:0] x,
                                               input logic [2:0] s);
    logic signed [DW+1:0] d;
    logic signed [DW+1:0] t;
    d = $signed({2'b00, x}) - $signed({2'b00, y});
    t = $signed({2'b00, y}) + (d >>> s);
    filt_step = t[DW-1:0];
  endfunction

  // State update; disabled channels keep their last value
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      for (int i = 0; i < N; i++) begin
        y_reg[i] <= '0;
      end
    end else if (fif.sample_valid) begin
      for (int i = 0; i < N; i++) begin
        if (fif.enable[i]) begin
          y_reg[i] <= filt_step(y_reg[i], fif.sample[i*DW +: DW], fif.shift);
        end
      end
    end
  end

  // Output valid one cycle after the sample
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= fif.sample_valid;
    end
  end

  // Present the state words
  always_comb begin
    fif.filtered = '0;
    for (int i = 0; i < N; i++) begin
      fif.filtered[i*DW +: DW] = y_reg[i];
    end
  end
  assign fif.filtered_valid = valid_reg;

  a_unity_pass: assert property (@(posedge mclk) disable iff (!nrst)
    fif.sample_valid && fif.shift == 3'h0 && fif.enable[0]
    |=> y_reg[0] == $past(fif.sample[DW-1:0]))
    else $error("K of one does not pass the sample");
endmodule
`default_nettype wire

// [tcs_pkg.sv]
/*
  Shared constants, types and helpers for the temperature and current-sense
  readout block. Assumes a 250 MHz core clock and a 200 us interleave step.
*/
`default_nettype none
package tcs_pkg;
  // Clock and interleave step
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned STEP_US = 200;
  localparam int unsigned STEP_CYCLES = STEP_US * CLK_MHZ;
  localparam int unsigned DATA_W = 12;
  localparam int unsigned NCH = 4;
  localparam int unsigned STEPS_W = 9;
  // Register indices, byte address is four times the index
  localparam logic [5:0] IDX_CFG0 = 6'h10;
  localparam logic [5:0] IDX_CFG1 = 6'h11;
  localparam logic [5:0] IDX_SEL = 6'h12;
  localparam logic [5:0] IDX_ISENSE0 = 6'h29;
  localparam logic [5:0] IDX_DIE = 6'h2d;
  localparam logic [5:0] IDX_REMOTE_ONE = 6'h2e;
  localparam logic [5:0] IDX_REMOTE_TWO = 6'h2f;
  localparam logic [5:0] IDX_STATUS = 6'h30;
  // Field positions
  localparam int unsigned CFG0_FILT_LSB = 0;
  localparam int unsigned CFG0_UPD_LSB = 3;
  localparam int unsigned CFG0_LOOP_BIT = 6;
  localparam int unsigned CFG1_GND_BIT = 0;
  localparam int unsigned SEL_DIE_BIT = 0;
  localparam int unsigned SEL_ONE_BIT = 1;
  localparam int unsigned SEL_TWO_BIT = 2;
  localparam int unsigned SEL_ISENSE_LSB = 4;
  localparam int unsigned STAT_FILT_BAD_BIT = 0;
  localparam int unsigned STAT_UPD_BAD_BIT = 1;
  localparam int unsigned STAT_BUSY_BIT = 2;
  localparam int unsigned STAT_LOOP_BIT = 3;
  // Reset values
  localparam logic [7:0] CFG0_RESET = 8'h00;
  localparam logic [7:0] CFG1_RESET = 8'h00;
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [2:0] FILT_MAX_CODE = 3'h4;
  localparam logic [2:0] UPD_MAX_CODE = 3'h5;
  // Update times in microseconds per field code
  localparam int unsigned FILT_UPD_US [5] = '{200, 3400, 6600, 13000, 25600};
  localparam int unsigned REMOTE_UPD_US [6] = '{16000, 16000, 18000, 26000, 50000, 98000};

  typedef enum logic [1:0] {CH_DIE, CH_ONE, CH_TWO} temp_chan_e;
  typedef logic [STEPS_W-1:0] steps_t;

  // Steps per filtered update; an invalid code runs at the fastest rate
  function automatic steps_t filt_steps(input logic [2:0] code);
    if (code > FILT_MAX_CODE) begin
      filt_steps = steps_t'(FILT_UPD_US[0] / STEP_US);
    end else begin
      filt_steps = steps_t'(FILT_UPD_US[code] / STEP_US);
    end
  endfunction

  // Steps per remote publish; an invalid code runs at the fastest rate
  function automatic steps_t remote_steps(input logic [2:0] code);
    if (code > UPD_MAX_CODE) begin
      remote_steps = steps_t'(REMOTE_UPD_US[0] / STEP_US);
    end else begin
      remote_steps = steps_t'(REMOTE_UPD_US[code] / STEP_US);
    end
  endfunction

  // Quarter-degree count to 12-bit two's complement, clamped
  function automatic logic [11:0] sat_code(input logic signed [12:0] q);
    if (q > 13'sh07ff) begin
      sat_code = 12'h7ff;
    end else if (q < 13'sh1800) begin
      sat_code = 12'h800;
    end else begin
      sat_code = q[11:0];
    end
  endfunction

  // Next enabled channel in die, remote one, remote two rotation
  function automatic temp_chan_e next_chan(input temp_chan_e last, input logic [2:0] en);
    logic [1:0] c;
    logic found;
    c = last;
    found = 1'b0;
    next_chan = last;
    for (int i = 0; i < 3; i++) begin
      c = (c == 2'd2) ? 2'd0 : c + 2'd1;
      if (!found && en[c]) begin
        next_chan = temp_chan_e'(c);
        found = 1'b1;
      end
    end
  endfunction
endpackage
`default_nettype wire

// [temp_current_sense_readout.sv]
/*
  Temperature and current-sense readout: conversion sequencing, result
  formatting, filtered current-sense hand-off and an Avalon-MM register slave.
  Assumes the analog converter answers each request with a one-cycle ack on
  the core clock, and a bus master that holds requests during waitrequest.
*/
`default_nettype none
module temp_current_sense_readout #(
  parameter int unsigned STEP_CYCLES = tcs_pkg::STEP_CYCLES
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic temp_conv_req,
  output tcs_pkg::temp_chan_e temp_conv_chan,
  input wire logic temp_conv_ack,
  input wire logic signed [12:0] temp_conv_quarter,
  output logic isense_conv_req,
  input wire logic isense_conv_ack,
  input wire logic [tcs_pkg::NCH*tcs_pkg::DATA_W-1:0] isense_conv_code,
  output logic grounded_collector_select,
  output logic loop_mode,
  output logic loop_feed_valid,
  output logic [tcs_pkg::NCH*tcs_pkg::DATA_W-1:0] loop_feed_data
);
  import tcs_pkg::*;

  typedef enum logic [1:0] {ST_WAIT, ST_TEMP, ST_ISENSE} seq_state_e;

  seq_state_e state_reg;
  temp_chan_e chan_reg;
  temp_chan_e last_reg;
  logic ack_reg;
  logic [31:0] readdata_reg;
  logic [7:0] cfg0_reg;
  logic [7:0] cfg1_reg;
  logic [7:0] sel_reg;
  logic [31:0] step_cnt_reg;
  logic step_tick;
  logic [DATA_W-1:0] die_res_reg;
  logic [DATA_W-1:0] one_latest_reg;
  logic [DATA_W-1:0] two_latest_reg;
  logic [DATA_W-1:0] one_res_reg;
  logic [DATA_W-1:0] two_res_reg;
  steps_t remote_cnt_reg;
  logic remote_pub;
  steps_t filt_cnt_reg;
  logic filt_pub;
  logic [DATA_W-1:0] isense_res_reg [NCH];
  logic feed_valid_reg;
  logic [NCH*DATA_W-1:0] feed_data_reg;
  logic [2:0] temp_en;
  logic [NCH-1:0] isense_en;
  logic [2:0] filt_code;
  logic [2:0] upd_code;
  logic [5:0] idx;
  logic bus_wr;
  logic temp_done;

  isense_filt_if #(.DW(DATA_W), .N(NCH)) fif ();

  // Field decode
  assign temp_en = {sel_reg[SEL_TWO_BIT], sel_reg[SEL_ONE_BIT], sel_reg[SEL_DIE_BIT]};
  assign isense_en = sel_reg[SEL_ISENSE_LSB +: NCH];
  assign filt_code = cfg0_reg[CFG0_FILT_LSB +: 3];
  assign upd_code = cfg0_reg[CFG0_UPD_LSB +: 3];
  assign idx = address[7:2];
  assign bus_wr = write && ack_reg;
  assign temp_done = (state_reg == ST_TEMP) && temp_conv_ack && temp_en[chan_reg];

  // One wait cycle on every access; keeps the read mux off the bus path
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (read || write) && !ack_reg;
    end
  end
  assign waitrequest = (read || write) && !ack_reg;

  // Read mux, captured in the wait cycle; unmapped reads as zero
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      readdata_reg <= 32'h0000_0000;
    end else if (read && !ack_reg) begin
      readdata_reg <= 32'h0000_0000;
      unique case (idx)
        IDX_CFG0: readdata_reg[7:0] <= cfg0_reg;
        IDX_CFG1: readdata_reg[7:0] <= cfg1_reg;
        IDX_SEL: readdata_reg[7:0] <= sel_reg;
        IDX_ISENSE0: readdata_reg[DATA_W-1:0] <= isense_res_reg[0];
        IDX_ISENSE0 + 6'h01: readdata_reg[DATA_W-1:0] <= isense_res_reg[1];
        IDX_ISENSE0 + 6'h02: readdata_reg[DATA_W-1:0] <= isense_res_reg[2];
        IDX_ISENSE0 + 6'h03: readdata_reg[DATA_W-1:0] <= isense_res_reg[3];
        IDX_DIE: readdata_reg[DATA_W-1:0] <= die_res_reg;
        IDX_REMOTE_ONE: readdata_reg[DATA_W-1:0] <= one_res_reg;
        IDX_REMOTE_TWO: readdata_reg[DATA_W-1:0] <= two_res_reg;
        IDX_STATUS: begin
          readdata_reg[STAT_FILT_BAD_BIT] <= filt_code > FILT_MAX_CODE;
          readdata_reg[STAT_UPD_BAD_BIT] <= upd_code > UPD_MAX_CODE;
          readdata_reg[STAT_BUSY_BIT] <= state_reg != ST_WAIT;
          readdata_reg[STAT_LOOP_BIT] <= loop_mode;
        end
        default: readdata_reg <= 32'h0000_0000;
      endcase
    end
  end
  assign readdata = readdata_reg;

  // Configuration registers, lane 0 only
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cfg0_reg <= CFG0_RESET;
      cfg1_reg <= CFG1_RESET;
      sel_reg <= SEL_RESET;
    end else if (bus_wr && byteenable[0]) begin
      if (idx == IDX_CFG0) begin
        cfg0_reg <= writedata[7:0];
      end
      if (idx == IDX_CFG1) begin
        cfg1_reg <= writedata[7:0];
      end
      if (idx == IDX_SEL) begin
        sel_reg <= writedata[7:0];
      end
    end
  end
  assign grounded_collector_select = cfg1_reg[CFG1_GND_BIT];
  assign loop_mode = cfg0_reg[CFG0_LOOP_BIT];

  // Interleave step timer
  always_ff @(posedge mclk) begin
    if (!nrst || step_tick) begin
      step_cnt_reg <= 32'h0000_0000;
    end else begin
      step_cnt_reg <= step_cnt_reg + 32'h0000_0001;
    end
  end
  assign step_tick = step_cnt_reg == 32'(STEP_CYCLES - 1);

  // Step sequencer: one temperature slot then one current slot per step
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_reg <= ST_WAIT;
      chan_reg <= CH_DIE;
      last_reg <= CH_TWO;
    end else begin
      unique case (state_reg)
        ST_WAIT: begin
          if (step_tick && |temp_en) begin
            state_reg <= ST_TEMP;
            chan_reg <= next_chan(last_reg, temp_en);
          end else if (step_tick && |isense_en) begin
            state_reg <= ST_ISENSE;
          end
        end
        ST_TEMP: begin
          if (temp_conv_ack) begin
            last_reg <= chan_reg;
            state_reg <= (|isense_en) ? ST_ISENSE : ST_WAIT;
          end
        end
        ST_ISENSE: begin
          if (isense_conv_ack) begin
            state_reg <= ST_WAIT;
          end
        end
      endcase
    end
  end
  assign temp_conv_req = state_reg == ST_TEMP;
  assign temp_conv_chan = chan_reg;
  assign isense_conv_req = state_reg == ST_ISENSE;

  // Temperature capture, dropped if the channel was disabled in flight
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      die_res_reg <= '0;
      one_latest_reg <= '0;
      two_latest_reg <= '0;
    end else if (temp_done) begin
      unique case (chan_reg)
        CH_DIE: die_res_reg <= sat_code(temp_conv_quarter);
        CH_ONE: one_latest_reg <= sat_code(temp_conv_quarter);
        CH_TWO: two_latest_reg <= sat_code(temp_conv_quarter);
        default: die_res_reg <= die_res_reg;
      endcase
    end
  end

  // Remote results published once per selected update time
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      remote_cnt_reg <= '0;
      one_res_reg <= '0;
      two_res_reg <= '0;
    end else if (remote_pub) begin
      remote_cnt_reg <= '0;
      one_res_reg <= one_latest_reg;
      two_res_reg <= two_latest_reg;
    end else if (step_tick) begin
      remote_cnt_reg <= remote_cnt_reg + steps_t'(1);
    end
  end
  assign remote_pub = step_tick && (remote_cnt_reg >= remote_steps(upd_code) - steps_t'(1));

  // Filter feed; K is two to the power of a valid field code, one for an invalid code
  assign fif.sample_valid = (state_reg == ST_ISENSE) && isense_conv_ack;
  assign fif.sample = isense_conv_code;
  assign fif.enable = isense_en;
  assign fif.shift = (filt_code > FILT_MAX_CODE) ? 3'h0 : filt_code;

  isense_filter #(.DW(DATA_W), .N(NCH)) u_filter (
    .mclk(mclk),
    .nrst(nrst),
    .fif(fif)
  );

  // Filtered update period counter
  always_ff @(posedge mclk) begin
    if (!nrst || filt_pub) begin
      filt_cnt_reg <= '0;
    end else if (step_tick) begin
      filt_cnt_reg <= filt_cnt_reg + steps_t'(1);
    end
  end
  assign filt_pub = step_tick && (filt_cnt_reg >= filt_steps(filt_code) - steps_t'(1));

  // Open loop: straight-binary results to registers, enabled channels only
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      for (int i = 0; i < NCH; i++) begin
        isense_res_reg[i] <= '0;
      end
    end else if (filt_pub && !loop_mode) begin
      for (int i = 0; i < NCH; i++) begin
        if (isense_en[i]) begin
          isense_res_reg[i] <= fif.filtered[i*DATA_W +: DATA_W];
        end
      end
    end
  end

  // Closed loop: hand the filtered set to the controllers
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      feed_valid_reg <= 1'b0;
      feed_data_reg <= '0;
    end else begin
      feed_valid_reg <= filt_pub && loop_mode;
      if (filt_pub && loop_mode) begin
        feed_data_reg <= fif.filtered;
      end
    end
  end
  assign loop_feed_valid = feed_valid_reg;
  assign loop_feed_data = feed_data_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_bus_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("Bus access not answered after one wait cycle");
  a_die_enable: assert property (!sel_reg[SEL_DIE_BIT] |=> $stable(die_res_reg))
    else $error("Die result changed while disabled");
  a_skip_disabled: assert property ($rose(temp_conv_req)
    |-> |($past(temp_en) & (3'h1 << chan_reg)))
    else $error("Disabled temperature channel requested");
  a_rotate_order: assert property ($rose(temp_conv_req) && $past(temp_en) == 3'h7
    |-> chan_reg == ((last_reg == CH_TWO) ? CH_DIE : temp_chan_e'(last_reg + 2'd1)))
    else $error("Temperature rotation out of order");
  a_die_format: assert property (temp_done && chan_reg == CH_DIE && temp_conv_quarter == 13'sh1f24
    |=> die_res_reg == 12'hf24)
    else $error("Minus 55 degrees encoded wrongly");
  a_sign_bit: assert property (temp_done && chan_reg == CH_DIE && !temp_conv_quarter[12]
    |=> !die_res_reg[11])
    else $error("Positive temperature stored with sign set");
  a_remote_hold: assert property (!$past(remote_pub) |-> $stable(one_res_reg))
    else $error("Remote result changed outside its update time");
  a_gnd_collector: assert property (bus_wr && byteenable[0] && idx == IDX_CFG1
    |=> grounded_collector_select == $past(writedata[0]))
    else $error("Grounded-collector select not taken from write");
  a_closed_hold: assert property (loop_mode && $past(loop_mode) |-> $stable(isense_res_reg[0]))
    else $error("Current result updated in closed loop");
  a_feed_loop: assert property (loop_feed_valid |-> $past(loop_mode) ##0 $past(filt_pub))
    else $error("Controller feed outside closed loop");

  c_feed: cover property (loop_feed_valid);
  c_remote_pub: cover property (remote_pub && temp_en[SEL_ONE_BIT]);
  c_negative_die: cover property (temp_done && chan_reg == CH_DIE && temp_conv_quarter[12]);
  c_open_result: cover property (filt_pub && !loop_mode && isense_en[0]);
endmodule
`default_nettype wire

// [temp_current_sense_readout_bench.sv]
/*
  Self-checking bench for the readout block with an Avalon master.
  Assumes the converter model answers every request it sees.
*/
`default_nettype none
module temp_current_sense_readout_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import tcs_pkg::*;
  logic mclk = 0, nrst = 0, read = 0, write = 0, slow = 0, tr_d = 0;
  logic [7:0] address = 8'h00;
  logic [31:0] writedata = 32'h0000_0000, rd;
  logic [3:0] byteenable = 4'hf;
  logic [12:0] qd = 13'h0000, q1 = 13'h1f9c, q2 = 13'h012c;
  logic [47:0] cs = 48'h0000_0000_0000;
  wire logic [31:0] readdata;
  wire logic waitrequest, tr, ta, ir, ia, gnd, lm, fv;
  wire temp_chan_e ch;
  wire logic signed [12:0] tq;
  wire logic [47:0] ic, fd;
  int n_mismatch = 0, n_tests = 0, cyc = 0;
  int chq[$];

  temp_current_sense_readout #(.STEP_CYCLES(20)) i_temp_current_sense_readout (.mclk(mclk),
    .nrst(nrst), .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .temp_conv_req(tr), .temp_conv_chan(ch), .temp_conv_ack(ta), .temp_conv_quarter(tq),
    .isense_conv_req(ir), .isense_conv_ack(ia), .isense_conv_code(ic),
    .grounded_collector_select(gnd), .loop_mode(lm), .loop_feed_valid(fv),
    .loop_feed_data(fd));
  converter_model i_converter_model (.mclk(mclk), .nrst(nrst), .slow(slow),
    .temp_conv_req(tr), .temp_conv_chan(ch), .q_die(qd), .q_one(q1), .q_two(q2),
    .cs_code(cs), .isense_conv_req(ir), .temp_conv_ack(ta), .temp_conv_quarter(tq),
    .isense_conv_ack(ia), .isense_conv_code(ic));

  // Clock and a hang guard well past the expected run
  initial begin
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      test_done();
    end
  end
  // Channel of every new temperature request, in order
  always @(posedge mclk) begin
    tr_d <= tr;
    if (tr && !tr_d) chq.push_back(int'(ch));
  end

  task automatic test_done();
    if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One Avalon access; the request holds until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do @(posedge mclk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask
  task automatic rst();
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
  endtask
  // Bounded wait for n new temperature requests
  task automatic waitn(input int n);
    for (int i = 0; i < 600 && chq.size() < n; i++) @(posedge mclk);
  endtask
  task automatic waitfv();
    for (int i = 0; i < 800 && fv !== 1'b1; i++) @(posedge mclk);
  endtask
  // Reference: quarter degrees clamped into a 12-bit two's complement word
  function automatic logic [31:0] et(input int q);
    if (q > 2047) q = 2047;
    if (q < -2048) q = -2048;
    return 32'(q) & 32'h0000_0fff;
  endfunction

  initial begin
    int qv[5] = '{500, 100, -220, -1, 3000};
    int q, c, n;
    logic [31:0] r6[5] = '{32'h0000_01f4, 32'h0000_0064, 32'h0000_0f24, 32'h0000_0fff,
      32'h0000_07ff};
    logic [2:0] ens[4] = '{3'h5, 3'h6, 3'h3, 3'h7};
    void'($urandom(91636));
    rst();
    rdc(8'h40, 32'h0000_0000);
    rdc(8'h48, 32'h0000_0000);
    rdc(8'hb4, 32'h0000_0000);
    rdc(8'hfc, 32'h0000_0000);
    bus(1'b1, 8'hb4, 32'h0000_0123);
    rdc(8'hb4, 32'h0000_0000);
    byteenable <= 4'h0;
    bus(1'b1, 8'h44, 32'h0000_0001);
    byteenable <= 4'hf;
    @(posedge mclk);
    chk(32'(gnd), 32'h0000_0000);
    bus(1'b1, 8'h44, 32'h0000_0001);
    @(posedge mclk);
    chk(32'(gnd), 32'h0000_0001);
    // Every filter and update code, invalid ones flagged
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, 8'h40, 32'(k * 9));
      rdc(8'h40, 32'(k * 9));
      bus(1'b0, 8'hc0, 32'h0000_0000);
      chk(rd & 32'h0000_0003, 32'(2 * (k > 5) + (k > 4)));
    end
    bus(1'b1, 8'h40, 32'h0000_0000);
    bus(1'b1, 8'h48, 32'h0000_0001);
    for (int i = 0; i < 9; i++) begin
      q = (i < 5) ? qv[i] : int'($urandom_range(4095)) - 2048;
      qd <= 13'(q);
      slow <= i[0];
      chq.delete();
      waitn(2);
      rdc(8'hb4, (i < 5) ? r6[i] : et(q));
      chk(32'(chq[0]), 32'h0000_0000);
    end
    bus(1'b1, 8'h48, 32'h0000_0000);
    // Let a slot started at the write edge finish before watching
    repeat (30) @(posedge mclk);
    n = q;
    q = int'($urandom_range(1000));
    qd <= 13'(q);
    chq.delete();
    repeat (100) @(posedge mclk);
    chk(32'(chq.size()), 32'h0000_0000);
    rdc(8'hb4, et(n));
    // Open loop: current codes reach the result registers unchanged
    cs <= {$urandom(), 16'($urandom())};
    bus(1'b1, 8'h48, 32'h0000_00f0);
    repeat (100) @(posedge mclk);
    for (int k = 0; k < 4; k++) rdc(8'ha4 + 8'(4 * k), 32'(cs[k * 12 +: 12]));
    bus(1'b1, 8'h40, 32'h0000_0040);
    @(posedge mclk);
    chk(32'(lm), 32'h0000_0001);
    waitfv();
    chk(fd[31:0], cs[31:0]);
    bus(1'b1, 8'h40, 32'h0000_0041);
    waitfv();
    @(posedge mclk);
    waitfv();
    n = 1;
    @(posedge mclk);
    while (n < 800 && fv !== 1'b1) begin
      n++;
      @(posedge mclk);
    end
    chk(32'(n), 32'(17 * 20));
    chk(fd[47:16], cs[47:16]);
    // Rotation and skipping from a fresh reset; current sense off
    foreach (ens[e]) begin
      rst();
      bus(1'b1, 8'h48, 32'(ens[e]));
      chq.delete();
      waitn(4);
      c = 2;
      for (int j = 0; j < 4; j++) begin
        do c = (c + 1) % 3; while (!ens[e][c]);
        chk(32'(chq[j]), 32'(c));
      end
      repeat (1800) @(posedge mclk);
      rdc(8'hb8, ens[e][1] ? et(int'($signed(q1))) : 32'h0000_0000);
      rdc(8'hbc, ens[e][2] ? et(int'($signed(q2))) : 32'h0000_0000);
    end
    test_done();
  end
endmodule
`default_nettype wire
